/* rtl/sag_pkg.sv */
package sag_pkg;

  // ----------------------------------------------------------------
  // widths and address arithmetic
  // ----------------------------------------------------------------
  localparam int SEG_SHIFT = 4;
  localparam int PHYS_W = 20;
  localparam int WORD_W = 16;
  localparam int IO_IMM_W = 8;

  // ----------------------------------------------------------------
  // internal control block
  // ----------------------------------------------------------------
  localparam int CB_OFS_W = 8;
  localparam logic [7:0] RELOC_OFS = 8'hFE;
  localparam logic [15:0] RELOC_RESET = 16'h20FF;
  localparam int RELOC_BASE_LSB = 0;
  localparam int RELOC_BASE_W = 12;
  localparam int RELOC_MEM_BIT = 12;
  localparam int RELOC_ALT_INT_BIT = 14;
  localparam int RELOC_COPROC_TRAP_BIT = 15;

  typedef enum logic [1:0] {
    REF_CODE,
    REF_STACK,
    REF_STRING_DST,
    REF_DATA
  } sag_ref_e;

  typedef enum logic [1:0] {
    SEG_EXTRA,
    SEG_CODE,
    SEG_STACK,
    SEG_DATA
  } sag_seg_e;

  typedef enum logic [1:0] {
    BASE_NONE,
    BASE_B,
    BASE_FRAME
  } sag_base_e;

  typedef enum logic [1:0] {
    IDX_NONE,
    IDX_SOURCE,
    IDX_DEST
  } sag_idx_e;

  typedef struct packed {
    sag_ref_e ref_kind;
    logic ovr_valid;
    sag_seg_e ovr_seg;
    logic disp_en;
    logic disp_wide;
    logic [15:0] disp;
    sag_base_e base_sel;
    sag_idx_e idx_sel;
  } sag_mem_req_s;

  typedef struct packed {
    logic [15:0] extra_segment_register;
    logic [15:0] code_segment_register;
    logic [15:0] stack_segment_register;
    logic [15:0] data_segment_register;
  } sag_segs_s;

  typedef struct packed {
    logic [15:0] base_reg_b;
    logic [15:0] frame_base_reg;
    logic [15:0] source_index_reg;
    logic [15:0] dest_index_reg;
    logic [15:0] port_pointer_reg;
  } sag_gprs_s;

endpackage : sag_pkg

/* rtl/sag_seg_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module sag_seg_sel (
  input var sag_pkg::sag_mem_req_s req,
  input var sag_pkg::sag_segs_s segs,
  output logic [15:0] seg_base
);

  sag_pkg::sag_seg_e implicit_seg;
  sag_pkg::sag_seg_e used_seg;

  always_comb begin
    if (req.ref_kind == sag_pkg::REF_CODE) begin
      implicit_seg = sag_pkg::SEG_CODE;
    end else if (req.ref_kind == sag_pkg::REF_STACK
                 || req.base_sel == sag_pkg::BASE_FRAME) begin
      implicit_seg = sag_pkg::SEG_STACK;
    end else if (req.ref_kind == sag_pkg::REF_STRING_DST
                 && req.idx_sel == sag_pkg::IDX_DEST) begin
      implicit_seg = sag_pkg::SEG_EXTRA;
    end else begin
      implicit_seg = sag_pkg::SEG_DATA;
    end
    used_seg = req.ovr_valid ? req.ovr_seg : implicit_seg;
    case (used_seg)
      sag_pkg::SEG_EXTRA: seg_base = segs.extra_segment_register;
      sag_pkg::SEG_CODE: seg_base = segs.code_segment_register;
      sag_pkg::SEG_STACK: seg_base = segs.stack_segment_register;
      default: seg_base = segs.data_segment_register;
    endcase
  end

endmodule : sag_seg_sel
`default_nettype wire

/* rtl/sag_eff_addr.sv */
`timescale 1ns/1ps
`default_nettype none
module sag_eff_addr (
  input var sag_pkg::sag_mem_req_s req,
  input var sag_pkg::sag_gprs_s gprs,
  input wire logic [15:0] seg_base,
  output logic [15:0] eff_ofs,
  output logic [19:0] phys_addr
);

  logic [15:0] disp_term;
  logic [15:0] base_term;
  logic [15:0] idx_term;

  always_comb begin
    // short displacement is signed
    if (!req.disp_en) begin
      disp_term = 16'h0000;
    end else if (req.disp_wide) begin
      disp_term = req.disp;
    end else begin
      disp_term = {{8{req.disp[7]}}, req.disp[7:0]};
    end
    case (req.base_sel)
      sag_pkg::BASE_B: base_term = gprs.base_reg_b;
      sag_pkg::BASE_FRAME: base_term = gprs.frame_base_reg;
      default: base_term = 16'h0000;
    endcase
    case (req.idx_sel)
      sag_pkg::IDX_SOURCE: idx_term = gprs.source_index_reg;
      sag_pkg::IDX_DEST: idx_term = gprs.dest_index_reg;
      default: idx_term = 16'h0000;
    endcase
    // any mix of the three terms covers all seven memory forms
    eff_ofs = 16'(disp_term + base_term + idx_term);
    // carry past bit 19 is dropped, so the space wraps
    phys_addr = 20'({seg_base, 4'h0} + {4'h0, eff_ofs});
  end

endmodule : sag_eff_addr
`default_nettype wire

/* rtl/sag_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module sag_addr_gen (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cyc_req,
  input wire logic cyc_write,
  input wire logic cyc_io,
  input wire logic port_imm_en,
  input wire logic [7:0] port_imm,
  input var sag_pkg::sag_mem_req_s mem_req,
  input var sag_pkg::sag_segs_s segs,
  input var sag_pkg::sag_gprs_s gprs,
  input wire logic [15:0] cyc_wdata,
  input wire logic [15:0] ext_data_in,
  input wire logic sync_ready_in,
  input wire logic async_ready_in,
  output logic [19:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic bus_io,
  output logic [15:0] bus_wdata,
  output logic cyc_done,
  output logic cyc_internal,
  output logic [15:0] cyc_rdata,
  output logic [15:0] control_block_relocation,
  output logic int_alt_mode,
  output logic coproc_trap_en
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXT_WAIT,
    ST_INT_DONE
  } sag_state_e;

  typedef struct packed {
    sag_state_e st;
    logic [19:0] addr;
    logic rd;
    logic wr;
    logic io;
    logic [15:0] wdata;
    logic done;
    logic internal;
    logic [15:0] rdata;
    logic [15:0] reloc;
  } sag_regs_s;

  sag_regs_s r;
  sag_regs_s next_r;

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  logic [15:0] seg_base;
  logic [15:0] eff_ofs;
  logic [19:0] mem_addr;
  logic [15:0] io_addr;
  logic [19:0] req_addr;
  logic req_hit;

  sag_seg_sel u_seg_sel (
    .req(mem_req),
    .segs(segs),
    .seg_base(seg_base)
  );

  sag_eff_addr u_eff_addr (
    .req(mem_req),
    .gprs(gprs),
    .seg_base(seg_base),
    .eff_ofs(eff_ofs),
    .phys_addr(mem_addr)
  );

  // decides whether an address falls in the relocatable block
  function automatic logic cb_hit(input logic [19:0] a, input logic is_io,
                                  input logic [15:0] reloc);
    logic [11:0] base;
    logic in_mem;
    base = reloc[sag_pkg::RELOC_BASE_LSB +: sag_pkg::RELOC_BASE_W];
    in_mem = reloc[sag_pkg::RELOC_MEM_BIT];
    // low eight bits never take part: the base is 256-byte aligned
    cb_hit = (in_mem != is_io) && (a[19:sag_pkg::CB_OFS_W] == base);
  endfunction : cb_hit

  always_comb begin
    // short port numbers leave the upper byte low
    if (port_imm_en) begin
      io_addr = {8'h00, port_imm};
    end else begin
      io_addr = gprs.port_pointer_reg;
    end
    // I/O space is its own 64K byte space; upper four bits stay low
    req_addr = cyc_io ? {4'h0, io_addr} : mem_addr;
    req_hit = cb_hit(req_addr, cyc_io, r.reloc);
  end

  // ----------------------------------------------------------------
  // bus cycle sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      ST_IDLE: begin
        if (cyc_req) begin
          // internal cycles drive address, strobes and data like external ones; only cyc_internal marks them
          next_r.addr = req_addr;
          next_r.io = cyc_io;
          next_r.rd = !cyc_write;
          next_r.wr = cyc_write;
          next_r.wdata = cyc_wdata;
          next_r.internal = req_hit;
          next_r.st = req_hit ? ST_INT_DONE : ST_EXT_WAIT;
        end
      end
      ST_EXT_WAIT: begin
        if (sync_ready_in || async_ready_in) begin
          next_r.rdata = r.rd ? ext_data_in : 16'h0000;
          next_r.rd = 1'b0;
          next_r.wr = 1'b0;
          next_r.done = 1'b1;
          next_r.st = ST_IDLE;
        end
      end
      ST_INT_DONE: begin
        // no ready wait and no external data are used here
        if (r.addr[sag_pkg::CB_OFS_W-1:0] == sag_pkg::RELOC_OFS) begin
          if (r.wr) begin
            next_r.reloc = r.wdata;
          end
          next_r.rdata = r.rd ? r.reloc : 16'h0000;
        end else begin
          // the peripherals behind other offsets live elsewhere
          next_r.rdata = 16'h0000;
        end
        next_r.rd = 1'b0;
        next_r.wr = 1'b0;
        next_r.done = 1'b1;
        next_r.st = ST_IDLE;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r.st <= ST_IDLE;
      r.addr <= 20'h00000;
      r.rd <= 1'b0;
      r.wr <= 1'b0;
      r.io <= 1'b0;
      r.wdata <= 16'h0000;
      r.done <= 1'b0;
      r.internal <= 1'b0;
      r.rdata <= 16'h0000;
      r.reloc <= sag_pkg::RELOC_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    bus_addr = r.addr;
    bus_rd = r.rd;
    bus_wr = r.wr;
    bus_io = r.io;
    bus_wdata = r.wdata;
    cyc_done = r.done;
    cyc_internal = r.internal;
    cyc_rdata = r.rdata;
    control_block_relocation = r.reloc;
    int_alt_mode = r.reloc[sag_pkg::RELOC_ALT_INT_BIT];
    coproc_trap_en = r.reloc[sag_pkg::RELOC_COPROC_TRAP_BIT];
  end

endmodule : sag_addr_gen
`default_nettype wire

/* verification/sag_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sag_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cyc_req,
  input wire logic sync_ready_in,
  input wire logic async_ready_in,
  input wire logic [19:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_io,
  input wire logic cyc_done,
  input wire logic cyc_internal,
  input wire logic [15:0] control_block_relocation,
  input wire logic int_alt_mode,
  input wire logic coproc_trap_en
);
  logic stb;
  logic rdy;
  logic [15:0] rl;
  assign stb = bus_rd | bus_wr;
  assign rdy = sync_ready_in | async_ready_in;
  assign rl = control_block_relocation;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_reset_value: assert property ($rose(rst_b) |-> rl == 16'h20FF)
    else $error("relocation not at reset value");
  a_mode_bits: assert property (int_alt_mode == rl[14] && coproc_trap_en == rl[15])
    else $error("mode outputs differ from relocation bits");
  a_io_upper_zero: assert property (stb && bus_io |-> bus_addr[19:16] == 4'h0)
    else $error("io address above 16 bits");
  a_hit_decode: assert property ($rose(stb) |-> cyc_internal == (rl[12] ?
    (!bus_io && bus_addr[19:8] == rl[11:0]) : (bus_io && {4'h0, bus_addr[15:8]} == rl[11:0])))
    else $error("control block decode wrong");
  a_internal_len: assert property ($rose(stb) && cyc_internal |=> cyc_done)
    else $error("internal cycle not two cycles");
  a_ext_wait: assert property (stb && !cyc_internal && !rdy |=> !cyc_done)
    else $error("external cycle ended without ready");
  a_ext_end: assert property (stb && !cyc_internal && rdy |=> cyc_done ##1 !cyc_done)
    else $error("external cycle not ended after ready");
  a_strobe_cause: assert property ($rose(stb) |-> $past(cyc_req))
    else $error("strobe without request");
  a_strobe_end: assert property (cyc_done |-> !stb)
    else $error("strobe still high at done");
  cover property ($rose(bus_rd) && cyc_internal && !bus_io);
  cover property (stb && !cyc_internal && !rdy ##1 async_ready_in);
  cover property (cyc_done && bus_io && !cyc_internal);
endmodule : sag_props
bind sag_addr_gen sag_props u_sag_props (.ref_clk, .rst_b, .cyc_req, .sync_ready_in,
  .async_ready_in, .bus_addr, .bus_rd, .bus_wr, .bus_io, .cyc_done, .cyc_internal,
  .control_block_relocation, .int_alt_mode, .coproc_trap_en);
`default_nettype wire

/* verification/sag_ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module sag_ext_mem (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [19:0] bus_addr,
  input wire logic [3:0] wait_cyc,
  input wire logic use_async,
  output logic sync_ready_in,
  output logic async_ready_in,
  output logic [15:0] ext_data_in
);
  logic [3:0] cnt;
  // data toggles outside an answer so a stale value never passes for a read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt, sync_ready_in, async_ready_in, ext_data_in} <= '0;
    end else if ((bus_rd || bus_wr) && !(sync_ready_in || async_ready_in) && cnt == wait_cyc) begin
      sync_ready_in <= !use_async;
      async_ready_in <= use_async;
      ext_data_in <= bus_addr[15:0] ^ 16'hA5C3;
      cnt <= 4'h0;
    end else begin
      sync_ready_in <= 1'b0;
      async_ready_in <= 1'b0;
      ext_data_in <= ~ext_data_in;
      cnt <= (bus_rd || bus_wr) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : sag_ext_mem
`default_nettype wire

/* verification/segmented_address_generator_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module segmented_address_generator_bench;
  logic ref_clk, rst_b, cyc_req, cyc_write, cyc_io, port_imm_en, sync_ready_in, async_ready_in;
  logic bus_rd, bus_wr, bus_io, cyc_done, cyc_internal, int_alt_mode, coproc_trap_en, use_async;
  logic [15:0] cyc_wdata, ext_data_in, bus_wdata, cyc_rdata, control_block_relocation, p;
  logic [19:0] bus_addr, e;
  logic [7:0] port_imm;
  logic [3:0] wait_cyc;
  sag_pkg::sag_mem_req_s mem_req;
  sag_pkg::sag_segs_s segs;
  sag_pkg::sag_gprs_s gprs;
  integer seed;
  int miscompares, total_checks;
  sag_addr_gen u_sag_addr_gen (.ref_clk, .rst_b, .cyc_req, .cyc_write, .cyc_io, .port_imm_en,
    .port_imm, .mem_req, .segs, .gprs, .cyc_wdata, .ext_data_in, .sync_ready_in,
    .async_ready_in, .bus_addr, .bus_rd, .bus_wr, .bus_io, .bus_wdata, .cyc_done,
    .cyc_internal, .cyc_rdata, .control_block_relocation, .int_alt_mode, .coproc_trap_en);
  sag_ext_mem u_sag_ext_mem (.ref_clk, .rst_b, .bus_rd, .bus_wr, .bus_addr, .wait_cyc,
    .use_async, .sync_ready_in, .async_ready_in, .ext_data_in);
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [19:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [19:0] ea(sag_pkg::sag_mem_req_s r);
    logic [15:0] o;
    int k;
    k = int'(sag_pkg::SEG_DATA);
    if (r.ref_kind == sag_pkg::REF_CODE) k = int'(sag_pkg::SEG_CODE);
    else if (r.ref_kind == sag_pkg::REF_STACK || r.base_sel == sag_pkg::BASE_FRAME)
      k = int'(sag_pkg::SEG_STACK);
    else if (r.ref_kind == sag_pkg::REF_STRING_DST && r.idx_sel == sag_pkg::IDX_DEST)
      k = int'(sag_pkg::SEG_EXTRA);
    if (r.ovr_valid) k = int'(r.ovr_seg);
    o = r.disp_en ? (r.disp_wide ? r.disp : {{8{r.disp[7]}}, r.disp[7:0]}) : 16'h0000;
    if (r.base_sel == sag_pkg::BASE_B) o += gprs.base_reg_b;
    if (r.base_sel == sag_pkg::BASE_FRAME) o += gprs.frame_base_reg;
    if (r.idx_sel == sag_pkg::IDX_SOURCE) o += gprs.source_index_reg;
    if (r.idx_sel == sag_pkg::IDX_DEST) o += gprs.dest_index_reg;
    return {segs[63-16*k -: 16], 4'h0} + {4'h0, o};
  endfunction : ea
  task automatic run(input logic w, io, input logic [15:0] wd);
    int n;
    @(posedge ref_clk);
    #1;
    {cyc_req, cyc_write, cyc_io, cyc_wdata} = {1'b1, w, io, wd};
    wait_cyc = 4'({$random(seed)} % 8);
    use_async = 1'($random(seed));
    @(posedge ref_clk);
    #1;
    cyc_req = 0;
    n = 0;
    while (cyc_done !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (cyc_done !== 1'b1) begin
      miscompares++;
      end_of_test;
    end
  endtask : run
  initial begin
    seed = 32'hE2B5FED6;
    {rst_b, cyc_req, cyc_write, cyc_io, port_imm_en, port_imm, cyc_wdata, wait_cyc} = '0;
    {use_async, mem_req, segs, gprs} = '0;
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1;
    chk("reloc", control_block_relocation, 16'h20FF);
    chk("modes", {int_alt_mode, coproc_trap_en}, 2'b00);
    for (int i = 0; i < 60; i++) begin
      mem_req = 27'($random(seed));
      mem_req.base_sel = sag_pkg::sag_base_e'(2'({$random(seed)} % 3));
      mem_req.idx_sel = sag_pkg::sag_idx_e'(2'({$random(seed)} % 3));
      segs = {$random(seed), $random(seed)};
      gprs = 80'({$random(seed), $random(seed), $random(seed)});
      cyc_write = 1'($random(seed));
      if (i == 0) begin
        // negative short displacement with both sums wrapping
        {mem_req, cyc_write} = '0;
        mem_req.ref_kind = sag_pkg::REF_DATA;
        mem_req.disp_en = 1'b1;
        mem_req.disp = 16'h0080;
        mem_req.base_sel = sag_pkg::BASE_B;
        segs.data_segment_register = 16'hFFFF;
        gprs.base_reg_b = 16'h0090;
      end
      e = ea(mem_req);
      run(cyc_write, 1'b0, segs[15:0]);
      chk("addr", bus_addr, e);
      chk("rdata", cyc_rdata, cyc_write ? 16'h0000 : e[15:0] ^ 16'hA5C3);
      chk("space", {bus_io, cyc_internal}, 2'b00);
      if (cyc_write) chk("wdata", bus_wdata, segs[15:0]);
    end
    for (int i = 0; i < 12; i++) begin
      port_imm_en = 1'(i);
      port_imm = 8'({$random(seed)} % 248);
      p = {1'b0, 15'($random(seed))} | 16'h0100;
      gprs.port_pointer_reg = p;
      e = port_imm_en ? {12'h000, port_imm} : {4'h0, p};
      run(1'b0, 1'b1, 16'h0000);
      chk("port", bus_addr, e);
      chk("prdata", {bus_io, cyc_rdata}, {1'b1, e[15:0] ^ 16'hA5C3});
    end
    port_imm_en = 1'b0;
    gprs.port_pointer_reg = 16'hFFFE;
    run(1'b0, 1'b1, 16'h0000);
    chk("cbread", {cyc_internal, cyc_rdata}, {1'b1, 16'h20FF});
    run(1'b1, 1'b1, 16'hD123);
    chk("cbwrite", {coproc_trap_en, int_alt_mode, control_block_relocation}, 18'h3D123);
    run(1'b0, 1'b1, 16'h0000);
    chk("oldio", cyc_internal, 1'b0);
    mem_req = '0;
    mem_req.ref_kind = sag_pkg::REF_DATA;
    {mem_req.disp_en, mem_req.disp_wide, mem_req.disp} = {2'b11, 16'h00FE};
    segs.data_segment_register = 16'h1230;
    run(1'b0, 1'b0, 16'h0000);
    chk("cbmem", {cyc_internal, cyc_rdata}, {1'b1, 16'hD123});
    run(1'b1, 1'b0, 16'h20FF);
    chk("back", control_block_relocation, 16'h20FF);
    // move the block once more, then reset in mid-run to see the value return
    run(1'b1, 1'b1, 16'hD123);
    chk("rewrite", control_block_relocation, 16'hD123);
    @(posedge ref_clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    chk("rereset", control_block_relocation, 16'h20FF);
    chk("remodes", {int_alt_mode, coproc_trap_en}, 2'b00);
    end_of_test;
  end
endmodule : segmented_address_generator_bench
`default_nettype wire
